/* File: shared/secp_pkg.sv */
// Package: constants for the serial calibration port block
// Summary of operation
// - Sixteen reads return word bits 15 down to 0 on data bit 7.
// - Four potentiometers addressed 00 offset, 01 gain, 10 out0, 11 out1.
// - Each potentiometer holds an eight-bit wiper setting 0 to 255.
// - Settings shift serially: register bit 7 is data, bit 0 is clock.
// - EEPROM port takes data bit 7, clock bit 0; read returns data on 7.
package secp_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0] SECP_EEPROM_PORT_OFS = 5'h18;
  localparam logic [4:0] SECP_CAL_PORT_OFS    = 5'h19;
  localparam int         SECP_DATA_BIT        = 7;
  localparam int         SECP_CLK_BIT         = 0;
  localparam logic [7:0] SECP_READ_RESET      = 8'h00;
  // ****************************************
  // Potentiometer shape
  // ****************************************
  localparam int         SECP_POT_COUNT       = 4;
  localparam int         SECP_POT_ADDR_BITS   = 2;
  localparam int         SECP_POT_DATA_BITS   = 8;
  localparam int         SECP_POT_FRAME_BITS  = 10;
  localparam logic [7:0] SECP_POT_RESET       = 8'h80;
  typedef enum logic [1:0] {
    SECP_POT_IDLE  = 2'b00,
    SECP_POT_SHIFT = 2'b01,
    SECP_POT_DONE  = 2'b10
  } secp_pot_state_t;
endpackage

/* File: hw/secp_pot.sv */
// One calibration potentiometer wiper register
module secp_pot
  import secp_pkg::*;
(
  input  wire logic                        ref_clk_i,
  input  wire logic                        nrst_i,
  input  wire logic                        load_i,
  input  wire logic [SECP_POT_DATA_BITS-1:0] value_i,
  output logic      [SECP_POT_DATA_BITS-1:0] wiper_o
);
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      wiper_o <= SECP_POT_RESET;
    end else if (load_i) begin
      wiper_o <= value_i;
    end
  end
endmodule

/* File: hw/secp_port.sv */
// Serial EEPROM and calibration potentiometer port
module secp_port
  import secp_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [4:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            ee_cs_o,
  output logic            ee_sclk_o,
  output logic            ee_sdi_o,
  input  wire logic       ee_sdo_i,
  output logic            pot_sclk_o,
  output logic            pot_sdi_o,
  output logic            pot_cs_n_o,
  output logic [7:0]      pot_offset_o,
  output logic [7:0]      pot_gain_o,
  output logic [7:0]      pot_out0_o,
  output logic [7:0]      pot_out1_o
);
  import secp_pkg::*;

  // ****************************************
  // Register writes drive the serial lines
  // ****************************************
  logic ee_wr;
  logic cal_wr;
  assign ee_wr  = wr_i && (addr_i == SECP_EEPROM_PORT_OFS);
  assign cal_wr = wr_i && (addr_i == SECP_CAL_PORT_OFS);

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ee_sdi_o  <= 1'b0;
      ee_sclk_o <= 1'b0;
      ee_cs_o   <= 1'b0;
    end else if (ee_wr) begin
      ee_sdi_o  <= wdata_i[SECP_DATA_BIT];
      ee_sclk_o <= wdata_i[SECP_CLK_BIT];
      // Chip select is raised by any nonzero write, whatever its data bit; 00 ends the frame
      ee_cs_o   <= (wdata_i != 8'h00);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pot_sdi_o  <= 1'b0;
      pot_sclk_o <= 1'b0;
    end else if (cal_wr) begin
      pot_sdi_o  <= wdata_i[SECP_DATA_BIT];
      pot_sclk_o <= wdata_i[SECP_CLK_BIT];
    end
  end

  // ****************************************
  // EEPROM data return
  // ****************************************
  // Outside pin: two flops before use
  logic sdo_m_q;
  logic sdo_s_q;
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sdo_m_q <= 1'b0;
      sdo_s_q <= 1'b0;
    end else begin
      sdo_m_q <= ee_sdo_i;
      sdo_s_q <= sdo_m_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= SECP_READ_RESET;
    end else if (rd_i && addr_i == SECP_EEPROM_PORT_OFS) begin
      rdata_o <= {sdo_s_q, 7'h00};
    end else if (rd_i) begin
      rdata_o <= SECP_READ_RESET;
    end
  end

  // ****************************************
  // Potentiometer frame receiver
  // ****************************************
  // Every calibration write with the clock bit set in the shift state clocks one bit in.
  // An edge detector on the held clock line would miss the plain load,
  // which keeps bit 0 high from the second write to the eleventh.
  secp_pot_state_t                  st_q;
  logic [3:0]                       cnt_q;
  logic [SECP_POT_FRAME_BITS-1:0]   sh_q;
  logic                             shift_en;
  logic                             end_wr;
  logic                             frame_done;
  assign shift_en   = cal_wr && wdata_i[SECP_CLK_BIT];
  assign end_wr     = cal_wr && (wdata_i == 8'h00);
  assign pot_cs_n_o = (st_q == SECP_POT_IDLE);

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_q  <= SECP_POT_IDLE;
      cnt_q <= 4'h0;
      sh_q  <= '0;
    end else begin
      case (st_q)
        SECP_POT_IDLE: begin
          // Enable byte: data high, clock low
          if (cal_wr && wdata_i[SECP_DATA_BIT] && !wdata_i[SECP_CLK_BIT]) begin
            st_q  <= SECP_POT_SHIFT;
            cnt_q <= 4'h0;
          end
        end
        SECP_POT_SHIFT: begin
          // An end byte mid-frame abandons it; no wiper is touched
          if (end_wr) begin
            st_q <= SECP_POT_IDLE;
          end else if (shift_en) begin
            sh_q  <= {sh_q[SECP_POT_FRAME_BITS-2:0], wdata_i[SECP_DATA_BIT]};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'(SECP_POT_FRAME_BITS - 1)) begin
              st_q <= SECP_POT_DONE;
            end
          end
        end
        SECP_POT_DONE: begin
          // end byte latches
          // Extra clocked writes here are ignored rather than shifted in
          if (end_wr) begin
            st_q <= SECP_POT_IDLE;
          end
        end
        default: st_q <= SECP_POT_IDLE;
      endcase
    end
  end

  assign frame_done = (st_q == SECP_POT_DONE) && end_wr;

  logic [7:0] wiper [SECP_POT_COUNT];
  genvar g;
  generate
    for (g = 0; g < SECP_POT_COUNT; g++) begin : g_pot
      secp_pot u_pot (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .load_i    (frame_done && sh_q[9:8] == 2'(g)),
        .value_i   (sh_q[7:0]),
        .wiper_o   (wiper[g])
      );
    end
  endgenerate
  assign pot_offset_o = wiper[0];
  assign pot_gain_o   = wiper[1];
  assign pot_out0_o   = wiper[2];
  assign pot_out1_o   = wiper[3];

  // ****************************************
  // Checks
  // ****************************************
  // EEPROM side: lines follow the latest write only
  ee_lines_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ee_wr |=> (ee_sdi_o == $past(wdata_i[7]) && ee_sclk_o == $past(wdata_i[0])))
    else $error("eeprom lines do not follow write");
  ee_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !ee_wr |=> $stable(ee_sdi_o) && $stable(ee_sclk_o) && $stable(ee_cs_o))
    else $error("eeprom lines moved without write");
  ee_open_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ee_wr && wdata_i != 8'h00 |=> ee_cs_o)
    else $error("eeprom select not raised");
  ee_close_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ee_wr && wdata_i == 8'h00 |=> !ee_cs_o)
    else $error("eeprom select not dropped");
  read_bit_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_i && addr_i == SECP_EEPROM_PORT_OFS |=> rdata_o == {$past(sdo_s_q), 7'h00})
    else $error("read data bit wrong");
  read_map_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rd_i && addr_i != SECP_EEPROM_PORT_OFS |=> rdata_o == SECP_READ_RESET)
    else $error("other offset read not zero");
  // Calibration side
  cal_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !cal_wr |=> $stable(pot_sdi_o) && $stable(pot_sclk_o))
    else $error("calibration lines moved without write");
  cal_lines_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cal_wr |=> pot_sclk_o == $past(wdata_i[0]))
    else $error("calibration clock not from bit 0");
  cal_data_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    cal_wr |=> pot_sdi_o == $past(wdata_i[SECP_DATA_BIT]))
    else $error("calibration data not from bit 7");
  // Frame receiver; wipers move only when a full frame meets its end byte
  frame_open_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    st_q == SECP_POT_IDLE && cal_wr && wdata_i[SECP_DATA_BIT] && !wdata_i[SECP_CLK_BIT]
    |=> !pot_cs_n_o && cnt_q == 4'h0)
    else $error("enable byte did not open frame");
  shift_bit_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    st_q == SECP_POT_SHIFT && shift_en
    |=> sh_q[0] == $past(wdata_i[SECP_DATA_BIT]) && cnt_q == $past(cnt_q) + 4'h1)
    else $error("clocked write did not shift one bit");
  frame_len_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    st_q == SECP_POT_SHIFT && shift_en && cnt_q == 4'h9 |=> st_q == SECP_POT_DONE)
    else $error("frame did not complete after ten bits");
  done_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    st_q == SECP_POT_DONE && !end_wr |=> st_q == SECP_POT_DONE)
    else $error("full frame left without end byte");
  end_byte_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    frame_done |=> st_q == SECP_POT_IDLE ##1 pot_cs_n_o)
    else $error("end byte did not close frame");
  pot_load_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    frame_done && sh_q[9:8] == 2'b01 |=> pot_gain_o == $past(sh_q[7:0]))
    else $error("gain pot not loaded");
  out_load_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    frame_done && sh_q[9:8] == 2'b11 |=> pot_out1_o == $past(sh_q[7:0]))
    else $error("output 1 pot not loaded");
  pot_keep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !frame_done |=> $stable(pot_offset_o))
    else $error("offset pot changed without load");
  out_keep_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !frame_done |=> $stable(pot_out0_o))
    else $error("output 0 pot changed without load");
endmodule

/* File: testbench/secp_ee_model.sv */
// Behavioural serial EEPROM that answers word reads
module secp_ee_model (
  input  wire logic ee_cs_i,
  input  wire logic ee_sclk_i,
  input  wire logic ee_sdi_i,
  output logic      ee_sdo_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int          cnt;
  logic [8:0]  hdr;
  logic [15:0] word;
  initial begin
    cnt = 0;
    hdr = 9'h000;
    word = 16'h0000;
    ee_sdo_o = 1'b1;
  end
  always @(posedge ee_sclk_i) begin
    if (ee_cs_i) begin
      cnt = cnt + 1;
      if (cnt <= 9) hdr = {hdr[7:0], ee_sdi_i};
      // Wrong start or opcode yields an all-zero word
      if (cnt == 9) word = (hdr[8:6] == 3'b110) ? {hdr[5:0], ~hdr[5:0], 4'h9} : 16'h0000;
      if (cnt >= 9 && cnt < 25) ee_sdo_o = word[24-cnt];
    end
  end
  // deselect ends exchange, released line flips
  always @(negedge ee_cs_i) begin
    cnt = 0;
    ee_sdo_o = ~ee_sdo_o;
  end
endmodule

/* File: testbench/tb_top.sv */
// Testbench for the serial calibration port
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top import secp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00, rdata_o, d, pv[4];
  logic ee_cs_o, ee_sclk_o, ee_sdi_o, ee_sdo_i, pot_sclk_o, pot_sdi_o, pot_cs_n_o;
  logic [7:0] pot_offset_o, pot_gain_o, pot_out0_o, pot_out1_o;
  logic [31:0] exp_w;
  logic [15:0] ew, rw;
  logic [9:0] fr;
  int n_mismatch = 0, checks = 0, cyc = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  secp_port dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ee_cs_o(ee_cs_o), .ee_sclk_o(ee_sclk_o),
    .ee_sdi_o(ee_sdi_o), .ee_sdo_i(ee_sdo_i), .pot_sclk_o(pot_sclk_o), .pot_sdi_o(pot_sdi_o),
    .pot_cs_n_o(pot_cs_n_o), .pot_offset_o(pot_offset_o), .pot_gain_o(pot_gain_o),
    .pot_out0_o(pot_out0_o), .pot_out1_o(pot_out1_o));
  secp_ee_model ee_u (.ee_cs_i(ee_cs_o), .ee_sclk_i(ee_sclk_o), .ee_sdi_i(ee_sdi_o), .ee_sdo_o(ee_sdo_i));
  task automatic finish_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // Four cycles per write gives a 160 ns serial clock
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    #1 addr_i = a;
    wdata_i = v;
    wr_i = 1'b1;
    @(posedge ref_clk_i);
    #1 wr_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  // Clock-low write first so every bit makes a fresh rising edge
  task automatic sbit(input logic [4:0] a, input logic b);
    wr(a, {b, 7'h02});
    wr(a, {b, 7'h03});
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    #1 addr_i = a;
    rd_i = 1'b1;
    @(posedge ref_clk_i);
    #1 rd_i = 1'b0;
    @(posedge ref_clk_i);
    #1 v = rdata_o;
  endtask
  initial begin
    pv = '{8'h4F, 8'h00, 8'hFF, 8'hA6};
    repeat (20) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    `CHK("wipers", 32'h80808080, {pot_out1_o, pot_out0_o, pot_gain_o, pot_offset_o})
    `CHK("idle", 3'b100, {pot_cs_n_o, ee_cs_o, rdata_o[7]})
    $display("test reset done");
    for (int p = 0; p < 4; p++) begin
      wr(5'h19, 8'h80);
      `CHK("pot open", 4'b0100, {pot_cs_n_o, pot_sdi_o, pot_sclk_o, ee_cs_o})
      fr = {2'(p), pv[p]};
      for (int i = 9; i >= 0; i--) sbit(5'h19, fr[i]);
      `CHK("pot lines", {1'b1, fr[0]}, {pot_sclk_o, pot_sdi_o})
      wr(5'h19, 8'h00);
      `CHK("pot close", 1'b1, pot_cs_n_o)
      for (int q = 0; q < 4; q++) exp_w[q*8+:8] = (q <= p) ? pv[q] : 8'h80;
      `CHK("wiper", exp_w, {pot_out1_o, pot_out0_o, pot_gain_o, pot_offset_o})
    end
    $display("test pot load done");
    fr = {2'b01, 8'h4F};
    wr(5'h19, 8'h80);
    for (int i = 9; i >= 0; i--) wr(5'h19, {fr[i], 7'h01});
    wr(5'h19, 8'h00);
    exp_w = {pv[3], pv[2], 8'h4F, pv[0]};
    `CHK("plain load", exp_w, {pot_out1_o, pot_out0_o, pot_gain_o, pot_offset_o})
    $display("test plain load done");
    foreach (pv[j]) begin
      fr[5:0] = (j == 0) ? 6'h04 : 6'h3F - 6'(j);
      ew = {fr[5:0], ~fr[5:0], 4'h9};
      wr(5'h18, 8'h80);
      `CHK("ee open", 3'b110, {ee_cs_o, ee_sdi_o, ee_sclk_o})
      for (int i = 8; i >= 0; i--) sbit(5'h18, (i > 5) ? (i != 6) : fr[i]);
      for (int k = 15; k >= 0; k--) begin
        rd(5'h18, d);
        `CHK("ee bit", {ew[k], 7'h00}, d)
        rw[k] = d[7];
        if (k > 0) sbit(5'h18, 1'b1);
      end
      wr(5'h18, 8'h00);
      `CHK("ee close", 3'b000, {ee_cs_o, ee_sdi_o, ee_sclk_o})
    end
    $display("test eeprom read done");
    fr = {2'b10, rw[7:0]};
    wr(5'h19, 8'h80);
    for (int i = 9; i >= 0; i--) wr(5'h19, {fr[i], 7'h01});
    wr(5'h19, 8'h00);
    `CHK("ee to pot", ew[7:0], pot_out0_o)
    $display("test eeprom to pot done");
    rd(5'h19, d);
    `CHK("cal read", 8'h00, d)
    rd(5'h1A, d);
    `CHK("unmapped", 8'h00, d)
    $display("test read map done");
    @(posedge ref_clk_i);
    #1 nrst_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1 nrst_i = 1'b1;
    `CHK("rst wipers", 32'h80808080, {pot_out1_o, pot_out0_o, pot_gain_o, pot_offset_o})
    `CHK("rst idle", 2'b10, {pot_cs_n_o, ee_cs_o})
    $display("test mid reset done");
    finish_test();
  end
endmodule
